// ---- hw/configurable_logic_block.sv ----
// Local design decisions: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "clb_consts.svh"

module configurable_logic_block (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [15:0] lut_in_i,
  input  wire logic [3:0]  direct_input_i,
  input  wire logic [1:0]  five_sel_i,
  input  wire logic        carry_in_i,
  input  wire logic        cell_clock_i,
  input  wire logic        cell_enable_i,
  input  wire logic        cell_clear_i,
  input  wire logic        global_reset_i,
  input  wire logic [3:0]  tbuf_data_i,
  input  wire logic        tbuf_enable_i,
  output logic      [3:0]  comb_o,
  output logic      [3:0]  direct_out_o,
  output logic      [3:0]  storage_o,
  output logic      [1:0]  five_input_o,
  output logic             carry_out_o,
  output logic      [3:0]  tbuf_data_o,
  output logic      [3:0]  tbuf_oe_o
);
  import clb_pkg::*;

  clb_state_t s_q;
  clb_state_t s_d;
  logic [3:0] lut_f;
  logic [4:0] carry;
  logic [3:0] edge_hit;
  logic [3:0] transp;
  logic [3:0] din;
  logic [3:0] enabled;
  logic       clear_now;
  logic [31:0] lut_merge;

  // truth table lookup, index is the four cell inputs
  function automatic logic lut_pick(input lut_word_t tt, input logic [3:0] a);
    lut_pick = tt[a];
  endfunction : lut_pick

  // byte-lane merge for wishbone writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old_w;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        r[8*b +: 8] = new_w[8*b +: 8];
    end
    lane_merge = r;
  endfunction : lane_merge

  function automatic logic [31:0] mode_word(input clb_state_t s);
    logic [31:0] w;
    w = '0;
    w[`CLB_MODE_LATCH_POS +: 4] = s.latch;
    w[`CLB_MODE_INV_POS +: 4]   = s.inv;
    w[`CLB_MODE_DSEL_POS +: 4]  = s.dsel;
    w[`CLB_MODE_CEUSE_POS +: 4] = s.ce_use;
    w[`CLB_MODE_CASC_POS +: 4]  = s.casc_or;
    w[`CLB_MODE_CLRUSE_POS]     = s.clr_use;
    mode_word = w;
  endfunction : mode_word

  // fabric inputs come from logic on clk_i, so no synchroniser is needed
  assign carry[0] = carry_in_i;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_cell
      assign lut_f[gi] = lut_pick(s_q.lut[gi], lut_in_i[4*gi +: 4]);
      // carry mux: pass on a match, force the decided value otherwise
      assign carry[gi+1] = s_q.casc_or[gi]
                           ? (lut_f[gi] ? 1'b1 : carry[gi])
                           : (lut_f[gi] ? carry[gi] : 1'b0);
      assign edge_hit[gi] = s_q.inv[gi]
                            ? (s_q.ck_prev & ~cell_clock_i)
                            : (~s_q.ck_prev & cell_clock_i);
      // latch open while the clock sits at its inactive level
      assign transp[gi] = ~(cell_clock_i ^ s_q.inv[gi]);
      assign enabled[gi] = ~s_q.ce_use[gi] | cell_enable_i;
      assign din[gi] = s_q.dsel[gi] ? direct_input_i[gi] : lut_f[gi];
    end
  endgenerate

  assign clear_now = (s_q.clr_use & cell_clear_i) | global_reset_i;

  always_comb
  begin
    s_d         = s_q;
    lut_merge   = lane_merge({16'h0000, s_q.lut[wb_adr_i[3:2]]},
                             wb_dat_i, wb_sel_i);
    s_d.ck_prev = cell_clock_i;
    for (int i = 0; i < 4; i++)
    begin
      if (s_q.latch[i])
      begin
        if (transp[i] & enabled[i])
          s_d.q[i] = din[i];
      end
      else if (edge_hit[i] & enabled[i])
        s_d.q[i] = din[i];
    end
    if (clear_now)
      s_d.q = 4'h0;

    // classic wishbone slave: ack one cycle after the strobe, for one cycle
    s_d.ack   = wb_cyc_i & wb_stb_i & ~s_q.ack;
    s_d.rdata = 32'h0000_0000;
    if (s_d.ack)
    begin
      case (wb_adr_i)
        `CLB_LUT0_OFF, `CLB_LUT1_OFF, `CLB_LUT2_OFF, `CLB_LUT3_OFF:
        begin
          s_d.rdata = {16'h0000, s_q.lut[wb_adr_i[3:2]]};
          if (wb_we_i)
            s_d.lut[wb_adr_i[3:2]] = lut_merge[15:0];
        end
        `CLB_MODE_OFF:
        begin
          s_d.rdata = mode_word(s_q);
          if (wb_we_i)
          begin
            s_d.rdata   = lane_merge(mode_word(s_q), wb_dat_i, wb_sel_i);
            s_d.latch   = s_d.rdata[`CLB_MODE_LATCH_POS +: 4];
            s_d.inv     = s_d.rdata[`CLB_MODE_INV_POS +: 4];
            s_d.dsel    = s_d.rdata[`CLB_MODE_DSEL_POS +: 4];
            s_d.ce_use  = s_d.rdata[`CLB_MODE_CEUSE_POS +: 4];
            s_d.casc_or = s_d.rdata[`CLB_MODE_CASC_POS +: 4];
            s_d.clr_use = s_d.rdata[`CLB_MODE_CLRUSE_POS];
            s_d.rdata   = mode_word(s_q);
          end
        end
        `CLB_STAT_OFF:
        begin
          s_d.rdata[`CLB_STAT_Q_POS +: 4] = storage_o;
          s_d.rdata[`CLB_STAT_X_POS +: 4] = lut_f;
          s_d.rdata[`CLB_STAT_CY_POS]     = carry[4];
        end
        default:
          s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // cell state is cleared by the bus reset as well as by global reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_q         <= '0;
      s_q.lut     <= {4{`CLB_LUT_RST}};
    end
    else
      s_q <= s_d;
  end

  // clear gates the output at once so it does not wait for a clock edge
  assign storage_o    = s_q.q & {4{~clear_now}};
  assign comb_o       = lut_f;
  assign direct_out_o = direct_input_i;
  assign five_input_o = {five_sel_i[1] ? lut_f[3] : lut_f[2],
                         five_sel_i[0] ? lut_f[1] : lut_f[0]};
  assign carry_out_o  = carry[4];
  assign tbuf_data_o  = tbuf_data_i;
  assign tbuf_oe_o    = {4{tbuf_enable_i}};
  assign wb_dat_o     = s_q.rdata;
  assign wb_ack_o     = s_q.ack;

endmodule : configurable_logic_block

// ---- shared/clb_consts.svh ----
`ifndef CLB_CONSTS_SVH
`define CLB_CONSTS_SVH

// register byte offsets on the wishbone bus
`define CLB_LUT0_OFF      8'h00
`define CLB_LUT1_OFF      8'h04
`define CLB_LUT2_OFF      8'h08
`define CLB_LUT3_OFF      8'h0C
`define CLB_MODE_OFF      8'h10
`define CLB_STAT_OFF      8'h14

// mode register field positions, each field four bits, one per cell, except the one-bit clear-use field at 20
`define CLB_MODE_LATCH_POS  0
`define CLB_MODE_INV_POS    4
`define CLB_MODE_DSEL_POS   8
`define CLB_MODE_CEUSE_POS  12
`define CLB_MODE_CASC_POS   16
`define CLB_MODE_CLRUSE_POS 20

// status register field positions
`define CLB_STAT_Q_POS      0
`define CLB_STAT_X_POS      4
`define CLB_STAT_CY_POS     8

// reset values
`define CLB_LUT_RST       16'h0000
`define CLB_MODE_RST      32'h0000_0000

`endif

// ---- shared/clb_pkg.sv ----
package clb_pkg;

  typedef logic [15:0] lut_word_t;

  typedef struct packed {
    lut_word_t [3:0] lut;
    logic [3:0]      latch;
    logic [3:0]      inv;
    logic [3:0]      dsel;
    logic [3:0]      ce_use;
    logic [3:0]      casc_or;
    logic            clr_use;
    logic [3:0]      q;
    logic            ck_prev;
    logic            ack;
    logic [31:0]     rdata;
  } clb_state_t;

endpackage : clb_pkg

// ---- testbench/clb_props.sv ----
`timescale 1ns/1ps
module clb_props (
  input logic       clk_i,
  input logic       rst_i,
  input logic       wb_cyc_i,
  input logic       wb_stb_i,
  input logic       wb_ack_o,
  input logic [3:0] direct_input_i,
  input logic [3:0] direct_out_o,
  input logic [3:0] tbuf_data_i,
  input logic [3:0] tbuf_data_o,
  input logic       tbuf_enable_i,
  input logic [3:0] tbuf_oe_o,
  input logic       global_reset_i,
  input logic [3:0] storage_o,
  input logic [1:0] five_sel_i,
  input logic [3:0] comb_o,
  input logic [1:0] five_input_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ans; wb_ack_o ##1 !wb_ack_o; endsequence
  property p_ack; s_req |=> s_ans; endproperty
  a_ack: assert property (p_ack) else $error("ack not one pulse");
  property p_dir; direct_out_o == direct_input_i; endproperty
  a_dir: assert property (p_dir) else $error("feed-through wrong");
  property p_oe; tbuf_oe_o == {4{tbuf_enable_i}}; endproperty
  a_oe: assert property (p_oe) else $error("buffer enable wrong");
  property p_tbd; tbuf_data_o == tbuf_data_i; endproperty
  a_tbd: assert property (p_tbd) else $error("buffer data wrong");
  property p_gr; global_reset_i |-> storage_o == 4'h0; endproperty
  a_gr: assert property (p_gr) else $error("reset not low");
  property p_gr2; global_reset_i |=> storage_o == 4'h0; endproperty
  a_gr2: assert property (p_gr2) else $error("reset not held");
  property p_f50;
    five_input_o[0] == (five_sel_i[0] ? comb_o[1] : comb_o[0]);
  endproperty
  a_f50: assert property (p_f50) else $error("low mux wrong");
  property p_f51;
    five_input_o[1] == (five_sel_i[1] ? comb_o[3] : comb_o[2]);
  endproperty
  a_f51: assert property (p_f51) else $error("high mux wrong");
endmodule : clb_props

bind configurable_logic_block clb_props clb_props_inst (.*);

// ---- testbench/fabric_model.sv ----
`timescale 1ns/1ps
module fabric_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic toggle_i,
  output logic      cell_clock_o
);
  // moves only on request, so each level stands several system clocks
  always_ff @(posedge clk_i)
    if (rst_i) cell_clock_o <= 1'b0;
    else if (toggle_i) cell_clock_o <= ~cell_clock_o;
endmodule : fabric_model

// ---- testbench/configurable_logic_block_tb.sv ----
`timescale 1ns/1ps
`include "clb_consts.svh"
module configurable_logic_block_tb;
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0, carry_in_i = 1'b0, cell_enable_i = 1'b0;
  logic        cell_clear_i = 1'b0, global_reset_i = 1'b0;
  logic        tbuf_enable_i = 1'b0, toggle = 1'b0;
  logic        cell_clock_i, wb_ack_o, carry_out_o;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF, direct_input_i = 4'h0, tbuf_data_i = 4'h0;
  logic [1:0]  five_sel_i = 2'h0, five_input_o;
  logic [15:0] lut_in_i = 16'h0000;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [3:0]  comb_o, direct_out_o, storage_o, tbuf_data_o, tbuf_oe_o;
  int          fail_count = 0, checked = 0;

  configurable_logic_block configurable_logic_block_inst (.*);
  fabric_model fabric_model_inst (.clk_i(clk_i), .rst_i(rst_i),
    .toggle_i(toggle), .cell_clock_o(cell_clock_i));

  initial forever #20 clk_i = ~clk_i;

  task finish_test;
    $display("checks %0d errors %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  // bounded wait: a dead slave ends up as a counted ack failure, not a hang
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && n++ < 20);
    if (wb_ack_o !== 1'b1)
    begin
      fail_count++;
      $display("CHECK FAILED wb ack expected 1 seen %b", wb_ack_o);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task pulse;
    @(posedge clk_i) toggle <= 1'b1;
    @(posedge clk_i) toggle <= 1'b0;
    tick(2);
  endtask : pulse

  task t_regs;
    wb(1'b0, `CLB_LUT0_OFF, 32'h0);
    chk("lut0 reset", rd, 32'h0);
    wb(1'b0, `CLB_MODE_OFF, 32'h0);
    chk("mode reset", rd, 32'h0);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", rd, 32'h0);
    wb(1'b1, `CLB_LUT3_OFF, 32'h1234_AAAA);
    wb(1'b0, `CLB_LUT3_OFF, 32'h0);
    chk("lut3 back", rd, 32'h0000_AAAA);
    for (int i = 0; i < 4; i++) wb(1'b1, 8'(i * 4), 32'h0000_AAAA);
  endtask : t_regs

  task t_comb;
    @(posedge clk_i);
    lut_in_i <= 16'h1010;
    five_sel_i <= 2'b01;
    direct_input_i <= 4'hA;
    tbuf_data_i <= 4'h5;
    tbuf_enable_i <= 1'b1;
    tick(1);
    chk("comb", comb_o, 4'b1010);
    chk("five", five_input_o, 2'b01);
    chk("direct", direct_out_o, 4'hA);
    chk("tbuf", {tbuf_oe_o, tbuf_data_o}, 8'hF5);
  endtask : t_comb

  task cy(input logic [31:0] m, input logic [15:0] l, input logic c, e);
    wb(1'b1, `CLB_MODE_OFF, m);
    @(posedge clk_i);
    lut_in_i <= l;
    carry_in_i <= c;
    tick(1);
    chk("carry", carry_out_o, e);
  endtask : cy

  task t_store;
    wb(1'b1, `CLB_MODE_OFF, 32'h0010_F124);
    @(posedge clk_i);
    lut_in_i <= 16'h1110;
    direct_input_i <= 4'h1;
    cell_enable_i <= 1'b1;
    tick(2);
    chk("latch open", storage_o, 4'b0100);
    pulse;
    chk("rise", storage_o, 4'b1101);
    @(posedge clk_i) lut_in_i <= 16'h0000;
    tick(2);
    chk("latch shut", storage_o, 4'b1101);
    @(posedge clk_i) cell_enable_i <= 1'b0;
    pulse;
    chk("enable low", storage_o, 4'b1101);
    @(posedge clk_i) cell_enable_i <= 1'b1;
    tick(2);
    chk("latch again", storage_o, 4'b1001);
    @(posedge clk_i) cell_clear_i <= 1'b1;
    tick(1);
    chk("clear", storage_o, 4'h0);
    @(posedge clk_i) cell_clear_i <= 1'b0;
    pulse;
    chk("reload", storage_o, 4'h1);
    @(posedge clk_i) global_reset_i <= 1'b1;
    tick(1);
    chk("global", storage_o, 4'h0);
    @(posedge clk_i) global_reset_i <= 1'b0;
    wb(1'b1, `CLB_MODE_OFF, 32'h0010_0000);
    @(posedge clk_i);
    cell_enable_i <= 1'b0;
    lut_in_i <= 16'h1111;
    pulse;
    pulse;
    chk("always on", storage_o, 4'hF);
  endtask : t_store

  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_comb;
    cy(32'h0, 16'h1111, 1'b1, 1'b1);
    cy(32'h0, 16'h1101, 1'b1, 1'b0);
    cy(32'h000F_0000, 16'h0000, 1'b0, 1'b0);
    cy(32'h000F_0000, 16'h0100, 1'b0, 1'b1);
    t_store;
    finish_test;
  end

  initial
  begin
    #400000;
    fail_count++;
    finish_test;
  end
endmodule : configurable_logic_block_tb
